/* verilog/qpot_device.sv */
// quad pot serial command decoder, device end
`timescale 1ns/1ps
`include "qpot_defines.svh"
module qpot_device (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // strapped select pins
  input  wire logic [1:0] i_device_select,
  // serial link
  qpot_link_if.device     link,
  // wiper outputs, pot n at bits 6n+5..6n
  output logic [23:0]     o_wiper_taps,
  output logic            o_write_busy
);
  import qpot_pkg::*;

  function automatic tap_type step_tap(input tap_type t, input logic up);
    if (up)
      step_tap = (t == 6'h3f) ? t : tap_type'(t + 6'h01);
    else
      step_tap = (t == 6'h00) ? t : tap_type'(t - 6'h01);
  endfunction

  logic [2:0] cs_sync;
  logic [2:0] sck_sync;
  logic [1:0] si_sync;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       frame;
  logic       ignore;
  logic [4:0] bit_cnt;
  logic [7:0] in_shift;
  logic [7:0] out_shift;
  logic [3:0] op;
  logic [1:0] reg_sel;
  logic [1:0] pot_sel;
  logic       reading;
  logic       store_due;
  tap_type    store_val;
  logic [15:0] busy_cnt;
  tap_type    wiper [4];
  tap_type    store [16];
  logic [7:0] next_byte;

  // bit 2 of each chain is only an edge history, never the sampled level
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sync  <= 3'h7;
      sck_sync <= 3'h0;
      si_sync  <= 2'h0;
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], link.cs_n};
      sck_sync <= {sck_sync[1:0], link.sck};
      si_sync  <= {si_sync[0], link.si};
      // strap pins are asynchronous; a rewired board must not glitch
      sel_meta <= i_device_select;
      sel_sync <= sel_meta;
    end
  end

  assign cs_fall  = cs_sync[2] & ~cs_sync[1];
  assign cs_rise  = ~cs_sync[2] & cs_sync[1];
  assign sck_rise = ~sck_sync[2] & sck_sync[1];
  assign sck_fall = sck_sync[2] & ~sck_sync[1];
  assign frame    = ~cs_sync[1];
  assign next_byte = {in_shift[6:0], si_sync[1]};

  // bit counter saturates so long step phases never wrap
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt  <= 5'h00;
      in_shift <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt  <= 5'h00;
    end else if (frame && sck_rise) begin
      in_shift <= next_byte;
      if (bit_cnt != 5'h1f)
        bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // header and instruction decode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ignore  <= 1'b0;
      op      <= 4'h0;
      reg_sel <= 2'h0;
      pot_sel <= 2'h0;
    end else if (cs_fall) begin
      ignore <= 1'b0;
      op     <= 4'h0;
    end else if (frame && sck_rise) begin
      if (bit_cnt == 5'h07 &&
          (next_byte != {`DEV_TYPE, 2'b00, sel_sync}))
        ignore <= 1'b1;
      if (bit_cnt == 5'h0f) begin
        op      <= next_byte[7:4];
        reg_sel <= next_byte[3:2];
        pot_sel <= next_byte[1:0];
      end
    end
  end

  // read data leaves on falling edges, MSB first
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_shift  <= 8'h00;
      reading    <= 1'b0;
      link.so    <= 1'b0;
      link.so_oe <= 1'b0;
    end else if (!frame || ignore) begin
      reading    <= 1'b0;
      link.so_oe <= 1'b0;
    end else if (sck_rise && bit_cnt == 5'h0f) begin
      reading <= 1'b1;
      unique case (next_byte[7:4])
        `OP_RD_WIPER:
          out_shift <= {2'b00, wiper[next_byte[1:0]]};
        `OP_RD_STORE:
          out_shift <= {2'b00, store[next_byte[3:0]]};
        `OP_STATUS:
          out_shift <= {7'h00, o_write_busy};
        default:
          reading <= 1'b0;
      endcase
    end else if (sck_fall && reading) begin
      link.so    <= out_shift[7];
      link.so_oe <= 1'b1;
      out_shift  <= {out_shift[6:0], 1'b0};
    end
  end

  // wiper registers: writes, transfers and steps act at once
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 4; p++)
        wiper[p] <= 6'h00;
    end else if (frame && !ignore && sck_rise) begin
      if (bit_cnt == 5'h17 && op == `OP_WR_WIPER)
        wiper[pot_sel] <= next_byte[5:0];
      else if (bit_cnt >= 5'h10 && op == `OP_STEP)
        wiper[pot_sel] <= step_tap(wiper[pot_sel], si_sync[1]);
    end else if (cs_rise && !ignore && bit_cnt == 5'h10) begin
      if (op == `OP_LOAD_ONE)
        wiper[pot_sel] <= store[{reg_sel, pot_sel}];
      else if (op == `OP_LOAD_ALL && pot_sel == 2'h0) begin
        for (int p = 0; p < 4; p++)
          wiper[p] <= store[{reg_sel, 2'(p)}];
      end
    end
  end

  // data byte held until deselect starts the store
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      store_due <= 1'b0;
      store_val <= 6'h00;
    end else if (cs_fall) begin
      store_due <= 1'b0;
    end else if (frame && sck_rise && bit_cnt == 5'h17 &&
                 op == `OP_WR_STORE) begin
      store_due <= 1'b1;
      store_val <= next_byte[5:0];
    end
  end

  // nonvolatile stores; new ones are dropped while a cycle runs
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 16; i++)
        store[i] <= 6'h00;
      busy_cnt     <= 16'h0000;
      o_write_busy <= 1'b0;
    end else if (cs_rise && !ignore && !o_write_busy &&
                 (store_due || (bit_cnt == 5'h10 &&
                  (op == `OP_SAVE_ONE ||
                   (op == `OP_SAVE_ALL && pot_sel == 2'h0))))) begin
      if (store_due)
        store[{reg_sel, pot_sel}] <= store_val;
      else if (op == `OP_SAVE_ONE)
        store[{reg_sel, pot_sel}] <= wiper[pot_sel];
      else begin
        for (int p = 0; p < 4; p++)
          store[{reg_sel, 2'(p)}] <= wiper[p];
      end
      busy_cnt     <= `WRITE_CYCLES;
      o_write_busy <= 1'b1;
    end else if (busy_cnt != 16'h0000) begin
      busy_cnt <= busy_cnt - 16'h0001;
      if (busy_cnt == 16'h0001)
        o_write_busy <= 1'b0;
    end
  end

  assign o_wiper_taps = {wiper[3], wiper[2], wiper[1], wiper[0]};
endmodule // qpot_device

/* verilog/qpot_defines.svh */
// constants shared by the quad pot link ends
// Behaviour
// - frame opens with type, zeros, device select
// - tap value is six low bits, MSB first
// - opcode 1001 reads selected wiper position
// - opcode 1010 writes third byte to wiper
// - opcode 1011 reads selected stored tap value
// - opcode 1100 writes stored value after deselect
// - opcode 1101 copies stored value to wiper
// - opcode 1110 stores wiper, starts write cycle
// - opcode 0010 steps until chip select rises
// - clock high with input high steps up
// - clock high with input low steps down
// - opcode 0001 loads all wipers from store
// - opcode 1000 stores all wipers, write cycle
// - write-in-progress flag during nonvolatile write
// - wiper load immediate, store takes write time
`ifndef QPOT_DEFINES_SVH
`define QPOT_DEFINES_SVH
`define DEV_TYPE      4'h5
`define OP_RD_WIPER   4'h9
`define OP_WR_WIPER   4'ha
`define OP_RD_STORE   4'hb
`define OP_WR_STORE   4'hc
`define OP_LOAD_ONE   4'hd
`define OP_SAVE_ONE   4'he
`define OP_LOAD_ALL   4'h1
`define OP_SAVE_ALL   4'h8
`define OP_STEP       4'h2
`define OP_STATUS     4'h5
`define STATUS_LOW    4'h1
`define REF_MHZ       25
`define WRITE_TIME_US 10
`define WRITE_CYCLES  16'(`WRITE_TIME_US * `REF_MHZ)
`define HALF_SCK      4'h8
`define REG_CMD       8'h00
`define REG_DATA      8'h04
`define REG_STATUS    8'h08
`define REG_INT_STAT  8'h0c
`define REG_INT_MASK  8'h10
`endif

/* verilog/qpot_pkg.sv */
// types shared by the quad pot link ends
package qpot_pkg;
  typedef logic [5:0] tap_type;
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} host_state_type;
endpackage

/* verilog/qpot_link_if.sv */
// serial link between controller and quad pot device
`timescale 1ns/1ps
interface qpot_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport device (input cs_n, sck, si, output so, so_oe);
  modport host (output cs_n, sck, si, input so, so_oe);
endinterface

/* verilog/qpot_host.sv */
// serial link controller with register port, host end
`timescale 1ns/1ps
`include "qpot_defines.svh"
module qpot_host (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  // serial link
  qpot_link_if.host        link
);
  import qpot_pkg::*;

  host_state_type state;
  logic [3:0]  phase;
  logic [7:0]  total;
  logic [7:0]  bit_cnt;
  logic [23:0] tx;
  logic        dir;
  logic [7:0]  rx;
  logic [7:0]  rx_data;
  logic [7:0]  tx_data;
  logic [1:0]  so_sync;
  logic        done;
  logic        int_stat;
  logic        int_mask;
  logic        start;
  logic [3:0]  cmd_op;

  assign start  = i_wr && i_addr == `REG_CMD && state == H_IDLE;
  assign cmd_op = i_wdata[7:4];

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      so_sync <= 2'h0;
    else
      so_sync <= {so_sync[0], link.so};
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      tx_data <= 8'h00;
    else if (i_wr && i_addr == `REG_DATA)
      tx_data <= i_wdata[7:0];
  end

  // link sequencer; the host makes the serial clock by dividing
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= H_IDLE;
      phase     <= 4'h0;
      bit_cnt   <= 8'h00;
      total     <= 8'h00;
      tx        <= 24'h000000;
      dir       <= 1'b0;
      rx        <= 8'h00;
      rx_data   <= 8'h00;
      done      <= 1'b0;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.si   <= 1'b0;
    end else begin
      done  <= 1'b0;
      phase <= phase + 4'h1;
      unique case (state)
        H_IDLE: begin
          if (start) begin
            // header byte, then instruction, then data byte
            // step frames repeat the direction bit after the instruction
            tx <= {`DEV_TYPE, 2'b00, i_wdata[9:8], i_wdata[7:0],
                   (cmd_op == `OP_STEP) ? {8{tx_data[7]}} : tx_data};
            link.si   <= 1'b0;
            dir       <= tx_data[7];
            bit_cnt   <= 8'h00;
            phase     <= 4'h0;
            link.cs_n <= 1'b0;
            state     <= H_LOW;
            unique case (cmd_op)
              `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_STORE, `OP_WR_STORE,
              `OP_STATUS:
                total <= 8'h18;
              `OP_STEP:
                total <= 8'h10 + {1'b0, tx_data[6:0]};
              default:
                total <= 8'h10;
            endcase
          end
        end
        H_LOW: begin
          if (phase == 4'h0)
            link.si <= tx[23];
          if (phase == `HALF_SCK - 4'h1) begin
            link.sck <= 1'b1;
            phase    <= 4'h0;
            state    <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (phase == `HALF_SCK - 4'h1) begin
            link.sck <= 1'b0;
            phase    <= 4'h0;
            rx       <= {rx[6:0], so_sync[1]};
            tx       <= {tx[22:0], dir};
            bit_cnt  <= bit_cnt + 8'h01;
            state    <= (bit_cnt + 8'h01 == total) ? H_GAP : H_LOW;
          end
        end
        H_GAP: begin
          // hold deselect long enough for the far end to see it
          if (phase == `HALF_SCK - 4'h1) begin
            if (!link.cs_n)
              rx_data <= rx;
            if (link.cs_n) begin
              done  <= 1'b1;
              state <= H_IDLE;
            end
            link.cs_n <= 1'b1;
            phase     <= 4'h0;
          end
        end
      endcase
    end
  end

  // done event is sticky; a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_stat <= 1'b0;
      int_mask <= 1'b0;
      o_irq    <= 1'b0;
    end else begin
      if (done)
        int_stat <= 1'b1;
      else if (i_wr && i_addr == `REG_INT_STAT && i_wdata[0])
        int_stat <= 1'b0;
      if (i_wr && i_addr == `REG_INT_MASK)
        int_mask <= i_wdata[0];
      o_irq <= int_stat & int_mask;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_rdata <= 32'h00000000;
    else if (i_rd) begin
      unique case (i_addr)
        `REG_DATA:     o_rdata <= {24'h000000, tx_data};
        `REG_STATUS:   o_rdata <= {23'h000000, state != H_IDLE, rx_data};
        `REG_INT_STAT: o_rdata <= {31'h00000000, int_stat};
        `REG_INT_MASK: o_rdata <= {31'h00000000, int_mask};
        default:       o_rdata <= 32'h00000000;
      endcase
    end else
      o_rdata <= 32'h00000000;
  end
endmodule // qpot_host

/* tb/qpot_link_checker.sv */
// assertions on the quad pot serial link and device outputs
`timescale 1ns/1ps
module qpot_link_checker (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  // link and device outputs
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        si,
  input wire logic        so,
  input wire logic        so_oe,
  input wire logic [23:0] o_wiper_taps,
  input wire logic        o_write_busy
);
  logic [8:0] busy_cnt;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // run length of the current write cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= '0;
    end else if (o_write_busy) begin
      busy_cnt <= busy_cnt + 9'h001;
    end else begin
      busy_cnt <= '0;
    end
  end

  AST_SO_FLOAT_DESEL: assert property (cs_n [*4] |-> !so_oe)
    else $error("serial output driven while deselected");
  AST_SCK_IDLE: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock moves outside a frame");
  AST_SCK_HIGH8: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
    else $error("serial clock high phase not eight cycles");
  AST_SI_STABLE: assert property (sck && $past(sck) |-> $stable(si))
    else $error("serial input changes in clock high phase");
  AST_BUSY_AFTER_CS: assert property ($rose(o_write_busy) |-> cs_n)
    else $error("write cycle starts inside a frame");
  AST_BUSY_LEN: assert property ($fell(o_write_busy) |->
    busy_cnt >= 9'h0fa && busy_cnt <= 9'h104)
    else $error("write cycle length out of range");
  AST_WIPER_IN_FRAME: assert property (!$stable(o_wiper_taps) |->
    !cs_n || !$past(cs_n, 6))
    else $error("wiper changes with no frame");
  AST_OE_START: assert property ($rose(so_oe) |-> !cs_n)
    else $error("serial output enabled outside a frame");
  AST_SO_HOLD: assert property (so_oe && sck && $past(sck) |->
    $stable(so))
    else $error("serial output changes in clock high phase");

  cover property ($rose(so_oe));
  cover property ($fell(o_write_busy));
  cover property (!cs_n && sck && si);
endmodule // qpot_link_checker

/* tb/quad_pot_serial_command_decoder_tb_top.sv */
// testbench joining host and device ends of the quad pot link
`timescale 1ns/1ps
`include "qpot_defines.svh"
module quad_pot_serial_command_decoder_tb_top;
  import qpot_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        o_irq;
  logic [23:0] o_wiper_taps;
  logic        o_write_busy;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_checks = 0;

  qpot_link_if link ();
  qpot_host qpot_host_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .link(link.host));
  qpot_device qpot_device_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_device_select(2'h1), .link(link.device),
    .o_wiper_taps(o_wiper_taps), .o_write_busy(o_write_busy));
  qpot_link_checker qpot_link_checker_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so(link.so), .so_oe(link.so_oe), .o_wiper_taps(o_wiper_taps),
    .o_write_busy(o_write_busy));

  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    rd = o_rdata;
  endtask

  task automatic wait_on(input bit use_irq);
    int n;
    n = 0;
    while ((use_irq ? o_irq !== 1'b1 : o_write_busy !== 1'b0)
           && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n == 20000) begin
      num_errors++;
      stop_test();
    end
  endtask

  // one whole frame, waits for the done interrupt and clears it
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat);
    wr(`REG_DATA, {24'h0, dat});
    wr(`REG_CMD, {22'h0, 2'h1, ins});
    wait_on(1'b1);
    wr(`REG_INT_STAT, 32'h1);
  endtask

  task automatic read_back(input logic [7:0] ins, input logic [7:0] exp);
    frame(ins, 8'h00);
    rdr(`REG_STATUS);
    check({16'h0, rd[7:0]}, {16'h0, exp});
  endtask

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    rdr(8'h14);
    check(rd[23:0], 24'h0);
    wr(`REG_INT_MASK, 32'h1);
    frame({`OP_WR_WIPER, 4'h1}, 8'h2a);
    check(o_wiper_taps, 24'h000a80);
    read_back({`OP_RD_WIPER, 4'h1}, 8'h2a);
    frame({`OP_WR_STORE, 4'h9}, 8'h15);
    check(o_write_busy, 24'h1);
    wait_on(1'b0);
    read_back({`OP_RD_STORE, 4'h9}, 8'h15);
    frame({`OP_LOAD_ONE, 4'h9}, 8'h00);
    check(o_wiper_taps, 24'h000540);
    frame({`OP_STEP, 4'h1}, 8'h83);
    check(o_wiper_taps, 24'h000600);
    frame({`OP_STEP, 4'h1}, 8'h05);
    check(o_wiper_taps, 24'h0004c0);
    frame({`OP_SAVE_ONE, 4'h1}, 8'h00);
    wait_on(1'b0);
    frame({`OP_WR_WIPER, 4'h3}, 8'h3f);
    frame({`OP_SAVE_ALL, 4'hc}, 8'h00);
    wait_on(1'b0);
    frame({`OP_LOAD_ALL, 4'h0}, 8'h00);
    check(o_wiper_taps, 24'h0004c0);
    read_back({`OP_RD_STORE, 4'hf}, 8'h3f);
    read_back({`OP_RD_STORE, 4'h1}, 8'h13);
    read_back({`OP_STATUS, `STATUS_LOW}, 8'h00);
    // foreign select with the done event masked
    wr(`REG_INT_MASK, 32'h0);
    wr(`REG_DATA, 32'h3f);
    wr(`REG_CMD, {22'h0, 2'h2, `OP_WR_WIPER, 4'h1});
    repeat (700) @(posedge i_ref_clk);
    check(o_irq, 24'h0);
    check(o_wiper_taps, 24'h0004c0);
    rdr(`REG_INT_STAT);
    check({23'h0, rd[0]}, 24'h1);
    wr(`REG_INT_MASK, 32'h1);
    repeat (3) @(posedge i_ref_clk);
    check(o_irq, 24'h1);
    wr(`REG_INT_STAT, 32'h1);
    repeat (3) @(posedge i_ref_clk);
    check(o_irq, 24'h0);
    stop_test();
  end
endmodule // quad_pot_serial_command_decoder_tb_top
